/* File: hw/dmc_map.svh */
// register map and field constants for the dram mode-control block
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
`define DMC_MODE_OFFSET 8'h7c
`define DMC_MODE_RESET 32'h0000_0008
`define DMC_REV_HI 31
`define DMC_REV_LO 30
`define DMC_INIT_BIT 29
`define DMC_PDN_BIT 28
`define DMC_RETRY_BIT 27
`define DMC_OVL_BIT 26
`define DMC_WAP_HI 25
`define DMC_WAP_LO 24
`define DMC_RAP_HI 23
`define DMC_RAP_LO 22
`define DMC_INT_HI 21
`define DMC_INT_LO 20
`define DMC_RSV_HI 19
`define DMC_RSV_LO 11
`define DMC_LOW_HI 10
`define DMC_LOW_LO 0
`define DMC_WRITE_MASK 32'h3ff0_07ff
`define DMC_ROW_PAIRS 4
`endif

/* File: hw/dmc_pkg.sv */
// types shared by the dram mode-control block
package dmc_pkg;
  typedef enum logic [1:0] {
    DMC_AP_SMART = 2'b00,
    DMC_AP_ALWAYS = 2'b01,
    DMC_AP_NEVER = 2'b10,
    DMC_AP_RSVD = 2'b11
  } dmc_ap_t;
  typedef enum logic [1:0] {
    DMC_ECC_NONE = 2'b00,
    DMC_ECC_72 = 2'b01,
    DMC_ECC_CHIPFAIL = 2'b10,
    DMC_ECC_RSVD = 2'b11
  } dmc_ecc_t;
  typedef enum logic [1:0] {
    DMC_RD_IDLE = 2'b00,
    DMC_RD_WAIT = 2'b01,
    DMC_RD_RETRY = 2'b10,
    DMC_RD_WAIT2 = 2'b11
  } dmc_rd_t;
endpackage : dmc_pkg

/* File: hw/dmc_mode_ctrl.sv */
// dram controller mode register and the mode logic it steers
//
// Notes on behaviour
// - bits 31:30 format revision are read-only, always read zero.
// - init done flag bit 29 resets to zero, only stored, firmware sets it.
// - with power-down enabled, a row pair with all banks closed enters power-down.
// - any access to a powered-down row pair brings it out of power-down.
// - power-down entry and exit are done by driving the row pair cke pins.
// - retry enabled with ecc on: a read with a double error is reissued exactly once.
// - overlap enable allows activates before a column command completes.
// - bits 25:24 pick the write auto-precharge policy.
// - bits 23:22 pick the read auto-precharge policy.
// - bits 21:20 pick no ecc, 72-bit ecc or chip-fail ecc.
// - no-ecc mode: no correction and nothing logged to error logs.
// - chip-fail ecc on a single channel acts as 72-bit ecc.
`timescale 1ns/1ns
`include "dmc_map.svh"
module dmc_mode_ctrl
  import dmc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  // configuration space access
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_hit_out,
  // per row-pair bank state from the scheduler
  input wire logic [`DMC_ROW_PAIRS-1:0] pair_all_closed_in,
  input wire logic [`DMC_ROW_PAIRS-1:0] pair_access_in,
  output logic [`DMC_ROW_PAIRS-1:0] cke_out,
  // read path
  input wire logic single_channel_in,
  input wire logic rd_issue_in,
  input wire logic rd_done_in,
  input wire logic rd_double_err_in,
  input wire logic rd_single_err_in,
  output logic rd_reissue_out,
  output logic rd_fail_out,
  output logic ecc_correct_en_out,
  output logic first_error_log_out,
  output logic next_error_log_out,
  // scheduler policy
  input wire logic col_busy_in,
  output logic act_allow_out,
  output dmc_ap_t wr_ap_mode_out,
  output dmc_ap_t rd_ap_mode_out,
  output dmc_ecc_t ecc_mode_out,
  output logic init_done_flag_out
);

  logic [31:0] mode_q;
  logic [31:0] next_mode;
  logic [31:0] byte_mask;
  logic [31:0] next_rdata;
  logic [`DMC_ROW_PAIRS-1:0] cke_q;
  logic [`DMC_ROW_PAIRS-1:0] next_cke;
  dmc_rd_t rd_q;
  dmc_rd_t next_rd;
  logic reissue_q;
  logic next_reissue;
  logic fail_q;
  logic next_fail;
  logic logged_q;
  logic next_logged;
  logic first_q;
  logic next_first;
  logic nextlog_q;
  logic next_nextlog;
  logic any_err;
  logic reg_hit;
  dmc_ecc_t eff_ecc;

  assign reg_hit = cfg_addr_in == `DMC_MODE_OFFSET;

  // byte enables widened to a bit mask
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_be
      assign byte_mask[gb*8 +: 8] = {8{cfg_be_in[gb]}};
    end
  endgenerate

  // register write; revision and reserved bits are outside the write mask
  always_comb
  begin
    next_mode = mode_q;
    next_rdata = 32'h0000_0000;
    if (cfg_wr_in && reg_hit)
    begin
      next_mode = (mode_q & ~(byte_mask & `DMC_WRITE_MASK))
                | (cfg_wdata_in & byte_mask & `DMC_WRITE_MASK);
    end
    if (cfg_rd_in && reg_hit)
    begin
      next_rdata = mode_q & `DMC_WRITE_MASK;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      mode_q <= `DMC_MODE_RESET;
      cfg_rdata_out <= 32'h0000_0000;
    end
    else
    begin
      mode_q <= next_mode;
      cfg_rdata_out <= next_rdata;
    end
  end

  assign cfg_hit_out = (cfg_rd_in | cfg_wr_in) & reg_hit;

  // decoded mode fields
  assign init_done_flag_out = mode_q[`DMC_INIT_BIT];
  assign wr_ap_mode_out = dmc_ap_t'(mode_q[`DMC_WAP_HI:`DMC_WAP_LO]);
  assign rd_ap_mode_out = dmc_ap_t'(mode_q[`DMC_RAP_HI:`DMC_RAP_LO]);

  // chip-fail needs both channels, so fall back when one is missing
  always_comb
  begin
    eff_ecc = dmc_ecc_t'(mode_q[`DMC_INT_HI:`DMC_INT_LO]);
    if (eff_ecc == DMC_ECC_CHIPFAIL && single_channel_in)
    begin
      eff_ecc = DMC_ECC_72;
    end
  end
  assign ecc_mode_out = eff_ecc;
  assign ecc_correct_en_out = eff_ecc != DMC_ECC_NONE;

  // activates may overlap a busy column only when allowed
  assign act_allow_out = mode_q[`DMC_OVL_BIT] | ~col_busy_in;

  // cke per row pair: drop when idle with power-down enabled, raise on any access or with power-down disabled
  always_comb
  begin
    for (int i = 0; i < `DMC_ROW_PAIRS; i++)
    begin
      next_cke[i] = cke_q[i];
      if (pair_access_in[i] || !mode_q[`DMC_PDN_BIT])
      begin
        next_cke[i] = 1'b1;
      end
      else if (pair_all_closed_in[i])
      begin
        next_cke[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      cke_q <= {`DMC_ROW_PAIRS{1'b1}};
    end
    else
    begin
      cke_q <= next_cke;
    end
  end
  assign cke_out = cke_q;

  // read retry: one reissue after a double error, a second failure is final
  assign any_err = rd_double_err_in | rd_single_err_in;
  always_comb
  begin
    next_rd = rd_q;
    next_reissue = 1'b0;
    next_fail = 1'b0;
    unique case (rd_q)
      DMC_RD_IDLE:
      begin
        if (rd_issue_in)
        begin
          next_rd = DMC_RD_WAIT;
        end
      end
      DMC_RD_WAIT:
      begin
        if (rd_done_in)
        begin
          if (rd_double_err_in && eff_ecc != DMC_ECC_NONE && mode_q[`DMC_RETRY_BIT])
          begin
            next_rd = DMC_RD_RETRY;
            next_reissue = 1'b1;
          end
          else
          begin
            next_rd = DMC_RD_IDLE;
            next_fail = rd_double_err_in && eff_ecc != DMC_ECC_NONE;
          end
        end
      end
      DMC_RD_RETRY:
      begin
        next_rd = DMC_RD_WAIT2;
      end
      DMC_RD_WAIT2:
      begin
        if (rd_done_in)
        begin
          next_rd = DMC_RD_IDLE;
          next_fail = rd_double_err_in && eff_ecc != DMC_ECC_NONE;
        end
      end
    endcase
  end

  // error logging: first error latches, later ones go to next log
  always_comb
  begin
    next_logged = logged_q;
    next_first = 1'b0;
    next_nextlog = 1'b0;
    if (rd_done_in && any_err && eff_ecc != DMC_ECC_NONE)
    begin
      next_first = !logged_q;
      next_nextlog = logged_q;
      next_logged = 1'b1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      rd_q <= DMC_RD_IDLE;
      reissue_q <= 1'b0;
      fail_q <= 1'b0;
      logged_q <= 1'b0;
      first_q <= 1'b0;
      nextlog_q <= 1'b0;
    end
    else
    begin
      rd_q <= next_rd;
      reissue_q <= next_reissue;
      fail_q <= next_fail;
      logged_q <= next_logged;
      first_q <= next_first;
      nextlog_q <= next_nextlog;
    end
  end
  assign rd_reissue_out = reissue_q;
  assign rd_fail_out = fail_q;
  assign first_error_log_out = first_q;
  assign next_error_log_out = nextlog_q;

  // checks
  rev_zero_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    $past(cfg_rd_in && reg_hit) |-> cfg_rdata_out[`DMC_REV_HI:`DMC_REV_LO] == 2'b00)
    else $error("revision field read nonzero");
  rsv_zero_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    mode_q[`DMC_RSV_HI:`DMC_RSV_LO] == 9'h000)
    else $error("reserved bits stored");
  init_store_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cfg_wr_in && reg_hit && cfg_be_in[3]
      |=> init_done_flag_out == $past(cfg_wdata_in[`DMC_INIT_BIT]))
    else $error("init flag not stored");
  pdn_enter_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    mode_q[`DMC_PDN_BIT] && pair_all_closed_in[0] && !pair_access_in[0] |=> !cke_out[0])
    else $error("idle pair not powered down");
  pdn_off_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !mode_q[`DMC_PDN_BIT] |=> cke_out == {`DMC_ROW_PAIRS{1'b1}})
    else $error("power-down used while disabled");
  pdn_exit_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    pair_access_in[0] |=> cke_out[0])
    else $error("accessed pair stayed down");
  retry_once_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    rd_reissue_out |=> !rd_reissue_out [*2])
    else $error("read reissued twice");
  no_retry_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !mode_q[`DMC_RETRY_BIT] |=> !rd_reissue_out)
    else $error("retry with retry disabled");
  overlap_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !mode_q[`DMC_OVL_BIT] && col_busy_in |-> !act_allow_out)
    else $error("overlap while disabled");
  fallback_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    single_channel_in |-> ecc_mode_out != DMC_ECC_CHIPFAIL)
    else $error("chip-fail on single channel");
  nolog_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ecc_mode_out == DMC_ECC_NONE |=> !first_error_log_out && !next_error_log_out)
    else $error("error logged in no-ecc mode");

endmodule : dmc_mode_ctrl

/* File: sim/dmc_dimm_model.sv */
// dimm-side model: answers reads after a latency, with commanded double errors
`timescale 1ns/1ns
module dmc_dimm_model #(parameter int LAT = 4)
(
  input wire logic clock_in,
  input wire logic req_in,
  input wire logic load_in,
  input wire logic [1:0] err_cnt_in,
  output logic done_out,
  output logic dbl_out,
  output logic sgl_out
);
  int t = 0;
  logic [1:0] left = 2'h0;
  initial done_out = 1'b0;
  initial dbl_out = 1'b0;
  initial sgl_out = 1'b0;
  // one read in flight; error lines toggle when idle so a stale flag never looks valid
  always @(posedge clock_in)
  begin
    done_out <= 1'b0;
    dbl_out <= ~dbl_out;
    sgl_out <= ~sgl_out;
    if (load_in)
      left <= err_cnt_in;
    if (req_in)
      t <= LAT;
    else if (t > 0)
      t <= t - 1;
    if (!req_in && t == 1)
    begin
      done_out <= 1'b1;
      dbl_out <= (left != 2'h0);
      sgl_out <= 1'b0;
      if (left != 2'h0)
        left <= left - 2'h1;
    end
  end
endmodule : dmc_dimm_model

/* File: sim/dram_mode_control_tb.sv */
// self-checking bench for the dram mode-control block
`timescale 1ns/1ns
`include "dmc_map.svh"
module dram_mode_control_tb;
  import dmc_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cfg_wr_in = 1'b0, cfg_rd_in = 1'b0, rd_d = 1'b0;
  logic [7:0] cfg_addr_in = 8'h00;
  logic [3:0] cfg_be_in = 4'h0, pair_all_closed_in = 4'h0, pair_access_in = 4'h0;
  logic [31:0] cfg_wdata_in = 32'h0, cfg_rdata_out, d, s;
  logic single_channel_in = 1'b0, rd_issue_in = 1'b0, col_busy_in = 1'b0;
  logic rd_done, dbl, sgl, rd_reissue_out, rd_fail_out, ecc_correct_en_out;
  logic first_log, next_log, act_allow_out, init_done_flag_out, ld = 1'b0, hit;
  logic [1:0] ecnt = 2'h0, e;
  logic [3:0] cke_out;
  dmc_ap_t wr_ap_mode_out, rd_ap_mode_out;
  dmc_ecc_t ecc_mode_out;
  logic [31:0] exp_q[$];
  int num_errors = 0, num_checks = 0, cyc = 0, n_re = 0, n_fail = 0, n_log = 0, n_first = 0;
  dmc_mode_ctrl DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .cfg_wr_in(cfg_wr_in),
    .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in),
    .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out), .cfg_hit_out(hit),
    .pair_all_closed_in(pair_all_closed_in), .pair_access_in(pair_access_in),
    .cke_out(cke_out), .single_channel_in(single_channel_in), .rd_issue_in(rd_issue_in),
    .rd_done_in(rd_done), .rd_double_err_in(dbl), .rd_single_err_in(sgl),
    .rd_reissue_out(rd_reissue_out), .rd_fail_out(rd_fail_out),
    .ecc_correct_en_out(ecc_correct_en_out), .first_error_log_out(first_log),
    .next_error_log_out(next_log), .col_busy_in(col_busy_in), .act_allow_out(act_allow_out),
    .wr_ap_mode_out(wr_ap_mode_out), .rd_ap_mode_out(rd_ap_mode_out),
    .ecc_mode_out(ecc_mode_out), .init_done_flag_out(init_done_flag_out));
  dmc_dimm_model MEM (.clock_in(clock_in), .req_in(rd_issue_in | rd_reissue_out),
    .load_in(ld), .err_cnt_in(ecnt), .done_out(rd_done), .dbl_out(dbl), .sgl_out(sgl));
  always #4 clock_in = ~clock_in;
  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge clock_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_be_in <= b;
    cfg_wdata_in <= v;
    @(posedge clock_in);
    // the decode flag stands while the strobe is still up at this edge
    chk("hit_wr", hit, a == `DMC_MODE_OFFSET);
    cfg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    exp_q.push_back(v);
    @(posedge clock_in);
    chk("hit_rd", hit, a == `DMC_MODE_OFFSET);
    cfg_rd_in <= 1'b0;
  endtask : rd
  // one read with a commanded number of double errors; pulse counts compared afterwards
  task automatic rd_case(input logic [31:0] m, input logic [1:0] k, input int xr, xf, xl);
    wr(8'h7c, 4'hf, m);
    n_re = 0;
    n_fail = 0;
    n_log = 0;
    ld <= 1'b1;
    ecnt <= k;
    @(posedge clock_in);
    ld <= 1'b0;
    rd_issue_in <= 1'b1;
    @(posedge clock_in);
    rd_issue_in <= 1'b0;
    repeat (20) @(posedge clock_in);
    chk("reissue", n_re, xr);
    if (xf >= 0)
      chk("fail", n_fail, xf);
    chk("logs", n_log, xl);
  endtask : rd_case
  // read data stands the cycle after the strobe; oldest note is taken then
  always @(posedge clock_in)
  begin
    if (rd_d)
      chk("rdata", cfg_rdata_out, exp_q.pop_front());
    rd_d <= cfg_rd_in;
    n_re += rd_reissue_out;
    n_fail += rd_fail_out;
    n_log += first_log + next_log;
    n_first += first_log;
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(94392));
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rd(8'h7c, `DMC_MODE_RESET);
    wr(8'h7c, 4'hf, 32'hffff_ffff);
    rd(8'h7c, 32'h3ff0_07ff);
    wr(8'h7c, 4'h8, 32'h0);
    rd(8'h7c, 32'h00f0_07ff);
    rd(8'h40, 32'h0);
    // random settings; the first two force chip-fail to hit both channel modes
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom();
      s = $urandom();
      if (i < 2)
      begin
        d[21:20] = 2'b10;
        s[0] = i[0];
      end
      @(posedge clock_in);
      single_channel_in <= s[0];
      col_busy_in <= s[1];
      wr(8'h7c, 4'hf, d);
      rd(8'h7c, d & `DMC_WRITE_MASK);
      #1;
      e = (d[21:20] == 2'b10 && s[0]) ? 2'b01 : d[21:20];
      chk("wr_ap", wr_ap_mode_out, d[25:24]);
      chk("rd_ap", rd_ap_mode_out, d[23:22]);
      chk("ecc", ecc_mode_out, e);
      chk("correct", ecc_correct_en_out, e != 2'b00);
      chk("act", act_allow_out, d[26] | !s[1]);
      chk("init", init_done_flag_out, d[29]);
    end
    @(posedge clock_in);
    single_channel_in <= 1'b0;
    col_busy_in <= 1'b0;
    pair_all_closed_in <= 4'hf;
    wr(8'h7c, 4'hf, 32'h0000_0008);
    repeat (3) @(posedge clock_in);
    chk("cke_off", cke_out, 4'hf);
    wr(8'h7c, 4'hf, 32'h1000_0008);
    repeat (3) @(posedge clock_in);
    chk("cke_pdn", cke_out, 4'h0);
    pair_access_in <= 4'h4;
    repeat (2) @(posedge clock_in);
    chk("cke_wake", cke_out, 4'h4);
    pair_access_in <= 4'h0;
    pair_all_closed_in <= 4'h0;
    wr(8'h7c, 4'hf, 32'h0000_0008);
    repeat (2) @(posedge clock_in);
    chk("cke_on", cke_out, 4'hf);
    // firmware keeps ecc on for normal traffic; no-ecc only as a debug case
    rd_case(32'h0810_0000, 2'h2, 1, 1, 2);
    rd_case(32'h0810_0000, 2'h1, 1, 0, 1);
    rd_case(32'h0010_0000, 2'h1, 0, 1, 1);
    rd_case(32'h0800_0000, 2'h2, 0, 0, 0);
    chk("first", n_first, 1);
    end_sim();
  end
endmodule : dram_mode_control_tb
